// [mstp_pkg.sv]
// Shared constants and types for the microstep translator and PWM block.
package mstp_pkg;

	// Clock period of pclk in nanoseconds.
	localparam int CLK_NS = 25;
	// Typical fixed off-time in nanoseconds.
	localparam int OFF_NS = 38000;
	// Typical blanking time in nanoseconds.
	localparam int BLANK_NS = 950;
	// Off-time in cycles, rounded down.
	localparam logic [15:0] OFF_CYC = 16'(OFF_NS / CLK_NS);
	// Blanking in cycles, rounded up.
	localparam logic [15:0] BLANK_CYC = 16'((BLANK_NS + CLK_NS - 1) / CLK_NS);

	// Register byte offsets.
	localparam logic [11:0] REG_OFF = 12'h000;
	localparam logic [11:0] REG_BLANK = 12'h004;
	localparam logic [11:0] REG_STAT = 12'h008;
	localparam logic [11:0] REG_DAC = 12'h00C;

	// Home index: the 45 degree entry of the eighth-step table.
	localparam logic [4:0] HOME_POS = 5'h04;
	// Magnitude of both phases at home, hundredths of a percent.
	localparam logic [13:0] HOME_MAG = 14'h1B9F;

	// Bit positions of the synchronised input vector.
	localparam int IN_STEP = 0;
	localparam int IN_DIR = 1;
	localparam int IN_RS0 = 2;
	localparam int IN_RS1 = 3;
	localparam int IN_RST_N = 4;
	localparam int IN_EN_N = 5;
	localparam int IN_SLP_N = 6;
	localparam int IN_DEC_HI = 7;
	localparam int IN_DEC_LO = 8;
	localparam int IN_OVT = 9;
	localparam int IN_UV = 10;
	localparam int IN_TRIP = 11;
	localparam int IN_NODE = 13;
	localparam int NUM_IN = 15;

	// Decay modes of one bridge.
	typedef enum logic [2:0] {
		DEC_SLOW = 3'h1,
		DEC_FAST = 3'h2,
		DEC_MIXED = 3'h4
	} mstp_decay_e;

	// Regulator states of one bridge.
	typedef enum logic [2:0] {
		PWM_ON = 3'h1,
		PWM_OFF_FAST = 3'h2,
		PWM_OFF_SLOW = 3'h4
	} mstp_pwm_e;

	// Four switches of one H bridge.
	typedef struct packed {
		logic src_a;
		logic snk_a;
		logic src_b;
		logic snk_b;
	} mstp_drive_s;

	// Level of one phase: sign and magnitude in hundredths of a percent.
	typedef struct packed {
		logic neg;
		logic [13:0] mag;
	} mstp_level_s;

	// Status word as read by software.
	typedef struct packed {
		logic [10:0] rsvd;
		logic home;
		logic uv;
		logic ovt;
		logic outs_on;
		mstp_pwm_e pwm1;
		mstp_pwm_e pwm0;
		mstp_decay_e dec1;
		mstp_decay_e dec0;
		logic [4:0] pos;
	} mstp_stat_s;

	// Magnitude of sine at an eighth-step index, hundredths of a percent.
	function automatic logic [13:0] sin_mag(input logic [4:0] idx);
		logic [3:0] t;
		t = (idx[3:0] <= 4'h8) ? idx[3:0] : 4'h0 - idx[3:0];
		case (t)
			4'h0: sin_mag = 14'h0000;
			4'h1: sin_mag = 14'h079F;
			4'h2: sin_mag = 14'h0EF3;
			4'h3: sin_mag = 14'h15B4;
			4'h4: sin_mag = 14'h1B9F;
			4'h5: sin_mag = 14'h207B;
			4'h6: sin_mag = 14'h2417;
			4'h7: sin_mag = 14'h2650;
			default: sin_mag = 14'h2710;
		endcase
	endfunction

endpackage

// [mstp_translator_pwm.sv]
// Microstep translator with fixed off-time PWM regulation for two bridges.
//
// Operation
// [R1] Reset loads home levels, mixed decay.
// [R2] Step moves both DACs to next entry.
// [R3] Falling level takes decay from setting input.
// [R4] Equal or rising level uses slow decay.
// [R5] Reset input holds home, outputs off.
// [R6] Steps ignored while reset input low.
// [R7] Only step rising edge advances one increment.
// [R8] Resolution change applies at next step.
// [R9] Direction level picks forward or backward walk.
// [R10] PWM cycle starts with diagonal pair on.
// [R11] Trip ends on-time; decay picks drivers off.
// [R12] One-shot holds drivers off for off-time.
// [R13] Comparator blanked after each switch-on.
// [R14] Enable low enables, high disables outputs.
// [R15] Translator inputs work regardless of enable.
// [R16] Overtemperature disables outputs until cleared.
// [R17] Undervoltage disables drivers, forces home.
// [R18] Sleep low disables; high starts at home.
// [R19] Setting level selects slow, fast or mixed.
// [R20] Mixed: fast until timing node reaches setting.
// [R21] Mixed: slow for rest of off-time.
// [R22] DAC trip is table percent over hundred.
// [R23] Select bits decode full, half, quarter, eighth.
// [R24] 32-entry table, home at 45 degrees.
// [R25] Index steps 8/4/2/1, wraps, reverses.
// [R26] Analog conditions are digital inputs, counts.
`timescale 1ns/10ps

module mstp_translator_pwm #(
	parameter int ADDR_W = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic step_in,
	input wire logic dir_in,
	input wire logic resolution_select_0,
	input wire logic resolution_select_1,
	input wire logic dev_reset_n,
	input wire logic out_enable_n,
	input wire logic sleep_n,
	input wire logic decay_setting_above_hi,
	input wire logic decay_setting_below_lo,
	input wire logic overtemp_fault,
	input wire logic supply_undervoltage_lockout,
	input wire logic [1:0] sense_trip,
	input wire logic [1:0] timing_node_at_setting,
	output mstp_pkg::mstp_drive_s [1:0] bridge_drive,
	output mstp_pkg::mstp_level_s [1:0] dac_level
);

	// Raw pin vector gathered for one synchroniser loop.
	logic [mstp_pkg::NUM_IN-1:0] raw_w;
	// Synchroniser stages and the debounced value.
	logic [mstp_pkg::NUM_IN-1:0] s1_q;
	logic [mstp_pkg::NUM_IN-1:0] s2_q;
	logic [mstp_pkg::NUM_IN-1:0] s3_q;
	logic [mstp_pkg::NUM_IN-1:0] in_q;

	// Analog comparators and faults arrive as plain digital levels. [R26]
	assign raw_w = {timing_node_at_setting, sense_trip,
		supply_undervoltage_lockout, overtemp_fault,
		decay_setting_below_lo, decay_setting_above_hi,
		sleep_n, out_enable_n, dev_reset_n,
		resolution_select_1, resolution_select_0, dir_in, step_in};

	// Every pin passes three flops; a change counts once stages two and three agree.
	// All stages reset low, so active-low pins read asserted at first and the block waits at home.
	genvar gi;
	generate
		for (gi = 0; gi < mstp_pkg::NUM_IN; gi++)
		begin : g_sync
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					s1_q[gi] <= 1'b0;
					s2_q[gi] <= 1'b0;
					s3_q[gi] <= 1'b0;
					in_q[gi] <= 1'b0;
				end
				else
				begin
					s1_q[gi] <= raw_w[gi];
					s2_q[gi] <= s1_q[gi];
					s3_q[gi] <= s2_q[gi];
					if (s2_q[gi] == s3_q[gi])
					begin
						in_q[gi] <= s3_q[gi];
					end
				end
			end
		end
	endgenerate

	// Software-set off-time and blanking, in pclk cycles.
	logic [15:0] off_cyc_q;
	logic [15:0] blank_cyc_q;
	// Previous step level for edge detection.
	logic step_prev_q;
	// Translator position and per-bridge state.
	logic [4:0] pos_q;
	logic [4:0] pos_d;
	mstp_pkg::mstp_decay_e [1:0] dec_q;
	mstp_pkg::mstp_decay_e [1:0] dec_d;
	mstp_pkg::mstp_level_s [1:0] lvl_q;
	mstp_pkg::mstp_level_s [1:0] lvl_d;
	mstp_pkg::mstp_pwm_e [1:0] pwm_q;
	mstp_pkg::mstp_pwm_e [1:0] pwm_d;
	logic [15:0] tmr_q [2];
	logic [15:0] tmr_d [2];
	mstp_pkg::mstp_drive_s [1:0] drv_q;
	mstp_pkg::mstp_drive_s [1:0] drv_d;

	// Home is forced by the reset pin, undervoltage or sleep. [R5] [R17] [R18]
	wire home_w = !in_q[mstp_pkg::IN_RST_N] || in_q[mstp_pkg::IN_UV]
		|| !in_q[mstp_pkg::IN_SLP_N];
	// Outputs need enable low and no fault or home condition. [R14] [R16]
	wire outs_on_w = !home_w && !in_q[mstp_pkg::IN_EN_N] && !in_q[mstp_pkg::IN_OVT];
	// A rising edge alone steps; enable plays no part in it. [R7] [R15]
	wire step_edge_w = in_q[mstp_pkg::IN_STEP] && !step_prev_q;
	// Steps count only while home is not forced. [R6]
	wire step_go_w = step_edge_w && !home_w;

	// Resolution is sampled live, so it only matters at a step edge. [R8] [R23]
	wire [1:0] res_w = {in_q[mstp_pkg::IN_RS1], in_q[mstp_pkg::IN_RS0]};
	wire [4:0] inc_w = 5'h08 >> res_w; // [R25]

	// Next index wraps modulo 32; direction high walks the table backward. [R9] [R25]
	wire [4:0] pos_fwd_w = pos_q + inc_w;
	wire [4:0] pos_rev_w = pos_q - inc_w;
	wire [4:0] pos_next_w = in_q[mstp_pkg::IN_DIR] ? pos_rev_w : pos_fwd_w;

	// Decay picked by the setting level. [R19]
	wire mstp_pkg::mstp_decay_e set_dec_w = in_q[mstp_pkg::IN_DEC_HI] ? mstp_pkg::DEC_SLOW
		: in_q[mstp_pkg::IN_DEC_LO] ? mstp_pkg::DEC_FAST : mstp_pkg::DEC_MIXED;

	// Translator next state: phase 0 follows cosine, phase 1 follows sine. [R24]
	always_comb
	begin
		logic [4:0] cidx;
		cidx = 5'h00;
		pos_d = pos_q;
		lvl_d = lvl_q;
		dec_d = dec_q;
		if (home_w)
		begin
			pos_d = mstp_pkg::HOME_POS;
		end
		else if (step_go_w)
		begin
			pos_d = pos_next_w; // [R2]
		end
		cidx = pos_d + 5'h08;
		// Levels hold hundredths of a percent of the maximum trip. [R22]
		lvl_d[0].mag = mstp_pkg::sin_mag(cidx);
		lvl_d[0].neg = cidx[4] && (cidx[3:0] != 4'h0);
		lvl_d[1].mag = mstp_pkg::sin_mag(pos_d);
		lvl_d[1].neg = pos_d[4] && (pos_d[3:0] != 4'h0);
		// Falling is judged on magnitude alone, since the comparator sees only size.
		for (int b = 0; b < 2; b++)
		begin
			if (home_w)
			begin
				dec_d[b] = mstp_pkg::DEC_MIXED; // [R1]
			end
			else if (step_go_w && lvl_d[b].mag < lvl_q[b].mag)
			begin
				dec_d[b] = set_dec_w; // [R3]
			end
			else if (step_go_w)
			begin
				dec_d[b] = mstp_pkg::DEC_SLOW; // [R4]
			end
		end
	end

	// Translator registers; chip reset lands on the home entry. [R1]
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			step_prev_q <= 1'b0;
			pos_q <= mstp_pkg::HOME_POS;
			lvl_q <= {2{1'b0, mstp_pkg::HOME_MAG}};
			dec_q <= '{mstp_pkg::DEC_MIXED, mstp_pkg::DEC_MIXED};
		end
		else
		begin
			step_prev_q <= in_q[mstp_pkg::IN_STEP];
			pos_q <= pos_d;
			lvl_q <= lvl_d;
			dec_q <= dec_d;
		end
	end

	// Per-bridge regulator: on with blanking, off for the one-shot time.
	// A release from disable counts as a switch-on, so it restarts blanking too.
	always_comb
	begin
		for (int b = 0; b < 2; b++)
		begin
			pwm_d[b] = pwm_q[b];
			tmr_d[b] = (tmr_q[b] != 16'h0000) ? tmr_q[b] - 16'h0001 : 16'h0000;
			drv_d[b] = '0;
			if (!outs_on_w)
			begin
				// Disabled bridges restart a fresh on-time when released.
				pwm_d[b] = mstp_pkg::PWM_ON;
				tmr_d[b] = blank_cyc_q;
			end
			else
			begin
				case (pwm_q[b])
					mstp_pkg::PWM_ON:
					begin
						// Trip is ignored while the blank timer runs. [R13]
						if (tmr_q[b] == 16'h0000 && in_q[mstp_pkg::IN_TRIP + b])
						begin
							pwm_d[b] = (dec_q[b] == mstp_pkg::DEC_SLOW)
								? mstp_pkg::PWM_OFF_SLOW : mstp_pkg::PWM_OFF_FAST; // [R11]
							tmr_d[b] = off_cyc_q; // [R12]
						end
					end
					mstp_pkg::PWM_OFF_FAST:
					begin
						if (tmr_q[b] == 16'h0000)
						begin
							pwm_d[b] = mstp_pkg::PWM_ON;
							tmr_d[b] = blank_cyc_q; // [R13]
						end
						else if (dec_q[b] == mstp_pkg::DEC_MIXED
							&& in_q[mstp_pkg::IN_NODE + b])
						begin
							pwm_d[b] = mstp_pkg::PWM_OFF_SLOW; // [R20] [R21]
						end
					end
					mstp_pkg::PWM_OFF_SLOW:
					begin
						if (tmr_q[b] == 16'h0000)
						begin
							pwm_d[b] = mstp_pkg::PWM_ON; // [R12]
							tmr_d[b] = blank_cyc_q; // [R13]
						end
					end
					default:
					begin
						pwm_d[b] = mstp_pkg::PWM_ON;
						tmr_d[b] = blank_cyc_q;
					end
				endcase
				// Drivers follow the state being entered.
				case (pwm_d[b])
					mstp_pkg::PWM_ON:
					begin
						// Diagonal pair sets the winding polarity. [R10]
						drv_d[b].src_a = !lvl_q[b].neg;
						drv_d[b].snk_b = !lvl_q[b].neg;
						drv_d[b].src_b = lvl_q[b].neg;
						drv_d[b].snk_a = lvl_q[b].neg;
					end
					mstp_pkg::PWM_OFF_SLOW:
					begin
						// Only the source drops; the sink keeps recirculating. [R11]
						drv_d[b].snk_b = !lvl_q[b].neg;
						drv_d[b].snk_a = lvl_q[b].neg;
					end
					default:
					begin
						drv_d[b] = '0; // [R11]
					end
				endcase
			end
		end
	end

	// Regulator registers; outputs start off.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pwm_q <= '{mstp_pkg::PWM_ON, mstp_pkg::PWM_ON};
			tmr_q[0] <= 16'h0000;
			tmr_q[1] <= 16'h0000;
			drv_q <= '0;
		end
		else
		begin
			pwm_q <= pwm_d;
			tmr_q[0] <= tmr_d[0];
			tmr_q[1] <= tmr_d[1];
			drv_q <= drv_d;
		end
	end

	// Drive and level ports leave their registers directly, so pins see no decode glitch.
	assign bridge_drive = drv_q;
	assign dac_level = lvl_q;

	// APB decode; the answer comes one cycle into the access phase.
	// Read data is captured a cycle early so prdata leaves a flop, not the mux.
	logic [31:0] rdata_q;
	logic ready_q;
	logic err_q;
	wire [11:0] addr_w = 12'(paddr);
	wire acc_w = psel && penable && !ready_q;
	wire done_w = psel && penable && ready_q;
	wire hit_off_w = addr_w == mstp_pkg::REG_OFF;
	wire hit_blank_w = addr_w == mstp_pkg::REG_BLANK;
	wire hit_stat_w = addr_w == mstp_pkg::REG_STAT;
	wire hit_dac_w = addr_w == mstp_pkg::REG_DAC;
	wire hit_w = hit_off_w || hit_blank_w || hit_stat_w || hit_dac_w;
	mstp_pkg::mstp_stat_s stat_w;
	assign stat_w = {11'h000, home_w, in_q[mstp_pkg::IN_UV], in_q[mstp_pkg::IN_OVT],
		outs_on_w, pwm_q[1], pwm_q[0], dec_q[1], dec_q[0], pos_q};
	wire [31:0] dac_w = {1'b0, lvl_q[1], 1'b0, lvl_q[0]};
	wire [31:0] rsel_w = hit_off_w ? {16'h0000, off_cyc_q}
		: hit_blank_w ? {16'h0000, blank_cyc_q}
		: hit_stat_w ? 32'(stat_w)
		: hit_dac_w ? dac_w : 32'h00000000;

	// Bus handshake and read capture; unmapped addresses answer with an error.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ready_q <= 1'b0;
			err_q <= 1'b0;
			rdata_q <= 32'h00000000;
		end
		else
		begin
			ready_q <= acc_w;
			err_q <= acc_w && !hit_w;
			if (acc_w && !pwrite)
			begin
				rdata_q <= rsel_w;
			end
		end
	end

	// Writes land at the completing edge; status and DAC words are read-only.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			off_cyc_q <= mstp_pkg::OFF_CYC;
			blank_cyc_q <= mstp_pkg::BLANK_CYC;
		end
		else if (done_w && pwrite && hit_off_w)
		begin
			off_cyc_q <= pwdata[15:0];
		end
		else if (done_w && pwrite && hit_blank_w)
		begin
			blank_cyc_q <= pwdata[15:0];
		end
	end

	// Bus outputs are the registered handshake values.
	assign prdata = rdata_q;
	assign pready = ready_q;
	assign pslverr = err_q;

endmodule // mstp_translator_pwm

// [mstp_props.sv]
// Checker for the translator and regulator block, bound to its top module.
`timescale 1ns/10ps
module mstp_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic step_in,
	input wire logic dev_reset_n,
	input wire logic out_enable_n,
	input wire logic sleep_n,
	input wire logic overtemp_fault,
	input wire logic supply_undervoltage_lockout,
	input wire mstp_pkg::mstp_drive_s [1:0] bridge_drive,
	input wire mstp_pkg::mstp_level_s [1:0] dac_level
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Both phases at the 45 degree entry, positive.
	localparam logic [29:0] HOME = {15'h1B9F, 15'h1B9F};
	// Bus phases of one transfer.
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence
	// Seven cycles covers the input filter latency plus the output register.
	a_ready_second: assert property (s_setup ##1 s_access |=> pready)
		else $error("ready missing in second access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_enable_off: assert property (out_enable_n [*7] |-> bridge_drive == '0)
		else $error("drive while outputs disabled");
	a_reset_home: assert property (!dev_reset_n [*7] |-> bridge_drive == '0 && dac_level == HOME)
		else $error("reset pin did not hold home");
	a_overtemp_off: assert property (overtemp_fault [*7] |-> bridge_drive == '0)
		else $error("drive during overtemperature");
	a_uv_home: assert property (supply_undervoltage_lockout [*7] |-> dac_level == HOME)
		else $error("undervoltage did not force home");
	a_sleep_home: assert property (!sleep_n [*7] |-> bridge_drive == '0 && dac_level == HOME)
		else $error("sleep did not force home and off");
	a_diag_pair: assert property (bridge_drive[0].src_a |-> bridge_drive[0].snk_b && !bridge_drive[0].snk_a)
		else $error("source without its diagonal sink");
	a_diag_neg: assert property (bridge_drive[1].src_b |-> bridge_drive[1].snk_a && !bridge_drive[1].snk_b)
		else $error("reverse source without its diagonal sink");
	// Resolution inputs are left free on purpose: they alone must not move the levels.
	a_level_hold: assert property (($stable(step_in) && dev_reset_n && sleep_n
		&& !supply_undervoltage_lockout) [*8] |-> $stable(dac_level))
		else $error("levels moved without a step");
endmodule // mstp_props

bind mstp_translator_pwm mstp_props u_props (.pclk, .presetn, .psel, .penable, .pready, .step_in,
	.dev_reset_n, .out_enable_n, .sleep_n, .overtemp_fault, .supply_undervoltage_lockout,
	.bridge_drive, .dac_level);

// [mstp_ctrl.sv]
// Step and direction controller model that drives the translator pins.
`timescale 1ns/10ps
module mstp_ctrl (
	input wire logic pclk,
	output logic step_in,
	output logic dir_in,
	output logic resolution_select_0,
	output logic resolution_select_1
);
	// Step idles low so no edge is seen before the first move.
	initial
	begin
		step_in = 1'b0;
		dir_in = 1'b0;
		resolution_select_0 = 1'b0;
		resolution_select_1 = 1'b0;
	end
	// Direction and resolution settle well before the rising edge and stay put after it.
	task automatic move(input logic d, input logic [1:0] res);
		@(posedge pclk);
		dir_in <= d;
		{resolution_select_1, resolution_select_0} <= res;
		repeat (6) @(posedge pclk);
		step_in <= 1'b1;
		repeat (8) @(posedge pclk);
		step_in <= 1'b0;
		repeat (8) @(posedge pclk);
	endtask
endmodule // mstp_ctrl

// [mstp_translator_pwm_control_tb_top.sv]
// Self-checking testbench for the translator and regulator block.
`timescale 1ns/10ps
module mstp_translator_pwm_control_tb_top;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, step_in, dir_in, resolution_select_0, resolution_select_1;
	logic dev_reset_n = 1'b1, out_enable_n = 1'b0, sleep_n = 1'b1, overtemp_fault = 1'b0;
	logic decay_setting_above_hi = 1'b0, decay_setting_below_lo = 1'b0;
	logic supply_undervoltage_lockout = 1'b0;
	logic [1:0] sense_trip = 2'h0, timing_node_at_setting = 2'h0;
	logic [7:0] r = 8'h3F;
	logic [14:0] o0, o1;
	mstp_pkg::mstp_drive_s [1:0] bridge_drive;
	mstp_pkg::mstp_level_s [1:0] dac_level;
	int bad_count = 0, comparisons = 0, pos = 4, i, k;
	// Table magnitudes in hundredths of a percent, 0 to 90 degrees.
	int mtab[9] = '{0, 1951, 3827, 5556, 7071, 8315, 9239, 9808, 10000};

	always #12.5 pclk = ~pclk;

	mstp_translator_pwm dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .step_in, .dir_in, .resolution_select_0, .resolution_select_1,
		.dev_reset_n, .out_enable_n, .sleep_n, .decay_setting_above_hi, .decay_setting_below_lo,
		.overtemp_fault, .supply_undervoltage_lockout, .sense_trip, .timing_node_at_setting,
		.bridge_drive, .dac_level);
	mstp_ctrl ctrl (.pclk, .step_in, .dir_in, .resolution_select_0, .resolution_select_1);

	// Signed level of a table index: sine folded over a quarter turn.
	function automatic logic [14:0] lvl(input int n);
		int t;
		t = n % 16;
		if (t > 8)
			t = 16 - t;
		return {((n % 32) >= 17) ? 1'b1 : 1'b0, 14'(mtab[t])};
	endfunction
	// Expected decay code: falling level takes the setting, else slow.
	function automatic logic [2:0] dexp(input logic [14:0] o, input logic [14:0] n);
		if (n[13:0] >= o[13:0])
			return 3'h1;
		return decay_setting_above_hi ? 3'h1 : (decay_setting_below_lo ? 3'h2 : 3'h4);
	endfunction
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e)
		begin
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
			bad_count++;
		end
	endtask
	task automatic results;
		$display("compared %0d, wrong %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// One bus transfer; a hung slave ends the run as a failure.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic err);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			bad_count++;
			results;
		end
		rd = prdata;
		chk({31'h0, pslverr}, {31'h0, err});
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle cycle keeps a following call from raising psel in this time step.
		@(posedge pclk);
	endtask

	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (8) @(posedge pclk);
		apb(1'b0, 12'h000, 32'h0, 1'b0);
		chk(rd, 32'h5F0);
		apb(1'b0, 12'h004, 32'h0, 1'b0);
		chk(rd, 32'h26);
		apb(1'b0, 12'h010, 32'h0, 1'b1);
		apb(1'b1, 12'h000, 32'h28, 1'b0);
		apb(1'b1, 12'h004, 32'h2, 1'b0);
		apb(1'b0, 12'h008, 32'h0, 1'b0);
		chk({21'h0, rd[10:0]}, 32'h484);
		// Random walk: direction, resolution, decay setting and enable all vary.
		for (i = 0; i < 24; i++)
		begin
			r = lfsr(r);
			o0 = lvl(pos + 8);
			o1 = lvl(pos);
			decay_setting_above_hi <= r[3];
			decay_setting_below_lo <= r[4];
			out_enable_n <= r[5];
			ctrl.move(r[0], r[2:1]);
			pos = (pos + (r[0] ? 32 - (8 >> r[2:1]) : (8 >> r[2:1]))) % 32;
			chk({2'h0, dac_level}, {2'h0, lvl(pos), lvl(pos + 8)});
			apb(1'b0, 12'h008, 32'h0, 1'b0);
			chk({21'h0, rd[10:0]}, {21'h0, dexp(o1, lvl(pos)), dexp(o0, lvl(pos + 8)), 5'(pos)});
		end
		out_enable_n <= 1'b0;
		dev_reset_n <= 1'b0;
		ctrl.move(1'b0, 2'h0);
		chk({2'h0, dac_level}, {2'h0, 15'h1B9F, 15'h1B9F});
		chk({24'h0, bridge_drive}, 32'h0);
		dev_reset_n <= 1'b1;
		repeat (8) @(posedge pclk);
		apb(1'b0, 12'h008, 32'h0, 1'b0);
		chk({21'h0, rd[10:0]}, 32'h484);
		chk({24'h0, bridge_drive}, 32'h99);
		// Trip on bridge 0 in mixed decay with the timing node low turns all its switches off; bridge 1 stays on.
		sense_trip <= 2'h1;
		repeat (8) @(posedge pclk);
		chk({24'h0, bridge_drive}, 32'h90);
		sense_trip <= 2'h0;
		repeat (60) @(posedge pclk);
		chk({24'h0, bridge_drive}, 32'h99);
		// With the timing node at the setting, mixed decay drops to slow: sink only.
		sense_trip <= 2'h1;
		timing_node_at_setting <= 2'h1;
		repeat (8) @(posedge pclk);
		chk({24'h0, bridge_drive}, 32'h91);
		sense_trip <= 2'h0;
		timing_node_at_setting <= 2'h0;
		repeat (60) @(posedge pclk);
		chk({24'h0, bridge_drive}, 32'h99);
		overtemp_fault <= 1'b1;
		repeat (8) @(posedge pclk);
		chk({24'h0, bridge_drive}, 32'h0);
		overtemp_fault <= 1'b0;
		repeat (8) @(posedge pclk);
		chk({24'h0, bridge_drive}, 32'h99);
		for (k = 0; k < 2; k++)
		begin
			ctrl.move(1'b0, 2'h0);
			// Index 12: phase 0 negative, phase 1 positive, so the diagonals differ.
			chk({24'h0, bridge_drive}, 32'h96);
			sleep_n <= (k != 0);
			supply_undervoltage_lockout <= (k == 1);
			repeat (8) @(posedge pclk);
			chk({2'h0, dac_level}, {2'h0, 15'h1B9F, 15'h1B9F});
			chk({24'h0, bridge_drive}, 32'h0);
			sleep_n <= 1'b1;
			supply_undervoltage_lockout <= 1'b0;
			repeat (8) @(posedge pclk);
		end
		results;
	end
endmodule // mstp_translator_pwm_control_tb_top
